// File: logic/uart_pkg.sv
// Package: shared constants and carriers for the FIFO serial port core.
// Assumes a single 25 MHz clock and synchronous active-high reset.
package uart_pkg;

  // ------------------------------------------------------------------
  // Clock source selection
  // ------------------------------------------------------------------
  localparam logic [1:0] CLKSEL_INT       = 2'h0;
  localparam logic [1:0] CLKSEL_INT_OUT   = 2'h1;
  localparam logic [1:0] CLKSEL_EXT       = 2'h2;
  localparam logic [1:0] CLKSEL_EXT_ALT   = 2'h3;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int          OVERSAMPLE      = 16;
  localparam logic [3:0]  SAMPLE_POINT    = 4'h7;
  localparam logic [3:0]  LAST_TICK       = 4'hf;
  localparam logic [7:0]  BIT_RATE_RESET  = 8'hff;
  localparam int          CLK_PERIOD_NS   = 40;

  // ------------------------------------------------------------------
  // Frame format
  // ------------------------------------------------------------------
  localparam logic [3:0]  DATA_BITS_8     = 4'h8;
  localparam logic [3:0]  DATA_BITS_7     = 4'h7;

  // Control word written as one unit (serial_control_reg)
  typedef struct packed {
    logic       receive_irq_enable;
    logic       transmit_irq_enable;
    logic       transmit_enable_bit;
    logic       receive_enable_bit;
    logic       clock_select_hi;
    logic       clock_select_lo;
  } serial_control_s;

  // Frame format (serial_mode_reg)
  typedef struct packed {
    logic       char_7bit;
    logic       parity_enable;
    logic       parity_odd;
    logic       two_stop;
  } serial_mode_s;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP
  } tx_state_e;

  typedef enum logic [2:0] {
    RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP
  } rx_state_e;

endpackage

// File: logic/tick_gen.sv
// Tick generator: 16x bit clock from internal divider or external pin.
// Assumes the external serial clock pin is synchronous to clk.
module tick_gen (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 use_ext,
  input  wire logic [7:0]           divisor,
  input  wire logic                 sck_in,
  output logic                      tick,
  output logic                      sck_level
);
  import uart_pkg::*;

  logic [7:0] div_cnt_r;
  logic       int_clk_r;
  logic       ext_prev_r;

  // ------------------------------------------------------------------
  // Internal divider: toggles once per divisor+1 clocks
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      div_cnt_r <= 8'h00;
      int_clk_r <= 1'b0;
    end else if (div_cnt_r >= divisor) begin
      div_cnt_r <= 8'h00;
      int_clk_r <= ~int_clk_r;
    end else begin
      div_cnt_r <= div_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= sck_in;
    end
  end

  // One tick per rising edge of the selected 16x clock
  always_comb begin
    if (use_ext) begin
      tick = sck_in & ~ext_prev_r;
    end else begin
      tick = (div_cnt_r >= divisor) & ~int_clk_r;
    end
  end

  assign sck_level = int_clk_r;

endmodule // tick_gen

// File: logic/fifo_serial_port.sv
// Serial port core: clock selection, frame engine, enable behaviour.
// Assumes software obeys the initialisation order; FIFOs sit outside.
//
// Notes on behaviour
// - Bit clock comes from internal divider or external pin, per select bits.
// - Internal clock with output selected drives pin at 16x bit rate.
// - Clock output starts one clock after the control word is registered.
// - Clearing transmit enable reinitialises the transmit shift register.
// - Clearing enables leaves transmit end status and FIFO contents untouched; clearing receive enable clears rx_data and rx error flags.
// - Transmit enable cleared mid-frame puts transmit data at high impedance.
// - Enable hands pin to port; transmitter marks, receiver awaits start.
// - Frame starts with one zero bit, then 8 or 7 bits LSB first.
// - Optional even or odd parity, then one or two stop bits.
module fifo_serial_port (
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire uart_pkg::serial_control_s ctrl,
  input  wire logic                     ctrl_we,
  input  wire uart_pkg::serial_mode_s   mode,
  input  wire logic [7:0]               bit_rate,
  input  wire logic                     sck_in,
  output logic                          sck_out,
  output logic                          sck_oe,
  input  wire logic [7:0]               tx_data,
  input  wire logic                     tx_valid,
  output logic                          tx_ready,
  output logic                          transmit_end_flag,
  output logic                          txd_out,
  output logic                          txd_oe,
  input  wire logic                     rxd_in,
  output logic [7:0]                    rx_data,
  output logic                          rx_valid,
  output logic                          rx_frame_err,
  output logic                          rx_parity_err
);
  import uart_pkg::*;

  // ------------------------------------------------------------------
  // Control word and clock selection
  // ------------------------------------------------------------------
  serial_control_s ctrl_r;
  logic            tick;
  logic            int_level;
  logic            use_ext;

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_r <= '0;
    end else if (ctrl_we) begin
      ctrl_r <= ctrl;
    end
  end

  assign use_ext = ctrl_r.clock_select_hi;

  tick_gen u_tick (
    .clk       (clk),
    .srst      (srst),
    .use_ext   (use_ext),
    .divisor   (bit_rate),
    .sck_in    (sck_in),
    .tick      (tick),
    .sck_level (int_level)
  );

  // Clock pin output follows divider, enabled one clock after control is registered
  always_ff @(posedge clk) begin
    if (srst) begin
      sck_oe  <= 1'b0;
      sck_out <= 1'b0;
    end else begin
      sck_oe  <= ({ctrl_r.clock_select_hi, ctrl_r.clock_select_lo}
                  == CLKSEL_INT_OUT);
      sck_out <= int_level;
    end
  end

  // ------------------------------------------------------------------
  // Transmitter
  // ------------------------------------------------------------------
  tx_state_e  tx_st_r;
  logic [3:0] tx_tick_r;
  logic [7:0] tx_shift_r;
  logic [3:0] tx_cnt_r;
  logic       tx_par_r;
  logic       tx_stop2_r;
  logic [3:0] nbits;
  logic       bit_end;

  assign nbits   = mode.char_7bit ? DATA_BITS_7 : DATA_BITS_8;
  assign bit_end = tick && (tx_tick_r == LAST_TICK);

  always_ff @(posedge clk) begin
    if (srst || !ctrl_r.transmit_enable_bit) begin
      tx_st_r    <= TX_IDLE;
      tx_tick_r  <= 4'h0;
      tx_shift_r <= 8'h00;
      tx_cnt_r   <= 4'h0;
      tx_par_r   <= 1'b0;
      tx_stop2_r <= 1'b0;
      txd_out    <= 1'b1;
      tx_ready   <= 1'b0;
    end else begin
      tx_ready <= 1'b0;
      if (tick) begin
        tx_tick_r <= tx_tick_r + 4'h1;
      end
      unique case (tx_st_r)
        TX_IDLE: begin
          txd_out   <= 1'b1;
          tx_tick_r <= 4'h0;
          if (tx_valid && !tx_ready) begin
            tx_shift_r <= tx_data;
            tx_par_r   <= mode.parity_odd;
            tx_cnt_r   <= 4'h0;
            tx_ready   <= 1'b1;
            txd_out    <= 1'b0;
            tx_st_r    <= TX_START;
          end
        end
        TX_START: begin
          if (bit_end) begin
            txd_out    <= tx_shift_r[0];
            tx_par_r   <= tx_par_r ^ tx_shift_r[0];
            tx_shift_r <= {1'b0, tx_shift_r[7:1]};
            tx_cnt_r   <= 4'h1;
            tx_st_r    <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (bit_end) begin
            if (tx_cnt_r == nbits) begin
              tx_stop2_r <= mode.two_stop;
              if (mode.parity_enable) begin
                txd_out <= tx_par_r;
                tx_st_r <= TX_PARITY;
              end else begin
                txd_out <= 1'b1;
                tx_st_r <= TX_STOP;
              end
            end else begin
              txd_out    <= tx_shift_r[0];
              tx_par_r   <= tx_par_r ^ tx_shift_r[0];
              tx_shift_r <= {1'b0, tx_shift_r[7:1]};
              tx_cnt_r   <= tx_cnt_r + 4'h1;
            end
          end
        end
        TX_PARITY: begin
          if (bit_end) begin
            txd_out <= 1'b1;
            tx_st_r <= TX_STOP;
          end
        end
        TX_STOP: begin
          if (bit_end) begin
            if (tx_stop2_r) begin
              tx_stop2_r <= 1'b0;
            end else begin
              tx_st_r <= TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Transmit end is status; enable changes do not touch it
  always_ff @(posedge clk) begin
    if (srst) begin
      transmit_end_flag <= 1'b1;
    end else if (tx_ready) begin
      transmit_end_flag <= 1'b0;
    end else if (tx_st_r == TX_STOP && bit_end && !tx_stop2_r &&
                 !tx_valid) begin
      transmit_end_flag <= 1'b1;
    end
  end

  // Pin released whenever transmitter is disabled, even mid-frame
  always_ff @(posedge clk) begin
    if (srst) begin
      txd_oe <= 1'b0;
    end else begin
      txd_oe <= ctrl.transmit_enable_bit & ctrl_we |
                ctrl_r.transmit_enable_bit & ~ctrl_we;
    end
  end

  // ------------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------------
  rx_state_e  rx_st_r;
  logic [3:0] rx_tick_r;
  logic [7:0] rx_shift_r;
  logic [3:0] rx_cnt_r;
  logic       rx_par_r;
  logic       rxd_prev_r;
  logic       mid;

  assign mid = tick && (rx_tick_r == SAMPLE_POINT);

  always_ff @(posedge clk) begin
    if (srst || !ctrl_r.receive_enable_bit) begin
      rx_st_r       <= RX_IDLE;
      rx_tick_r     <= 4'h0;
      rx_shift_r    <= 8'h00;
      rx_cnt_r      <= 4'h0;
      rx_par_r      <= 1'b0;
      rxd_prev_r    <= 1'b1;
      rx_data       <= 8'h00;
      rx_valid      <= 1'b0;
      rx_frame_err  <= 1'b0;
      rx_parity_err <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (tick) begin
        rxd_prev_r <= rxd_in;
        rx_tick_r  <= rx_tick_r + 4'h1;
      end
      unique case (rx_st_r)
        RX_IDLE: begin
          if (tick && rxd_prev_r && !rxd_in) begin
            rx_tick_r <= 4'h1;
            rx_st_r   <= RX_START;
          end
        end
        RX_START: begin
          if (mid) begin
            rx_st_r  <= rxd_in ? RX_IDLE : RX_DATA;
            rx_cnt_r <= 4'h0;
            rx_par_r <= mode.parity_odd;
          end
        end
        RX_DATA: begin
          if (mid) begin
            rx_shift_r <= {rxd_in, rx_shift_r[7:1]};
            rx_par_r   <= rx_par_r ^ rxd_in;
            rx_cnt_r   <= rx_cnt_r + 4'h1;
            if (rx_cnt_r + 4'h1 == nbits) begin
              rx_st_r <= mode.parity_enable ? RX_PARITY : RX_STOP;
            end
          end
        end
        RX_PARITY: begin
          if (mid) begin
            rx_par_r <= rx_par_r ^ rxd_in;
            rx_st_r  <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (mid) begin
            rx_data       <= mode.char_7bit ?
                             {1'b0, rx_shift_r[7:1]} : rx_shift_r;
            rx_valid      <= 1'b1;
            rx_frame_err  <= ~rxd_in;
            rx_parity_err <= mode.parity_enable & rx_par_r;
            rx_st_r       <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_txd_release: assert property (@(posedge clk) disable iff (srst)
    !ctrl_r.transmit_enable_bit |-> !txd_oe)
    else $error("txd driven while transmit disabled");
  a_tx_reinit: assert property (@(posedge clk) disable iff (srst)
    !ctrl_r.transmit_enable_bit |=> tx_st_r == TX_IDLE)
    else $error("tx shift not reinitialised");
  a_sck_drive: assert property (@(posedge clk) disable iff (srst)
    ctrl_we && ctrl.clock_select_lo && !ctrl.clock_select_hi
    |=> ##1 sck_oe)
    else $error("clock output late");
  a_idle_mark: assert property (@(posedge clk) disable iff (srst)
    ctrl_r.transmit_enable_bit && tx_st_r == TX_IDLE && !tx_ready
    |-> txd_out)
    else $error("idle line not at mark");
  a_start_low: assert property (@(posedge clk) disable iff (srst)
    tx_st_r == TX_START |-> !txd_out)
    else $error("start bit not low");
  a_stop_high: assert property (@(posedge clk) disable iff (srst)
    tx_st_r == TX_STOP |-> txd_out)
    else $error("stop bit not high");
  a_ext_tick: assert property (@(posedge clk) disable iff (srst)
    use_ext && tick |-> sck_in)
    else $error("tick not from external pin");
  a_transmit_end_flag_keep: assert property (@(posedge clk) disable iff (srst)
    $fell(ctrl_r.transmit_enable_bit) |-> $stable(transmit_end_flag))
    else $error("status changed by disable");
  a_rx_sample: assert property (@(posedge clk) disable iff (srst)
    rx_st_r == RX_IDLE ##1 rx_st_r == RX_START |-> rx_tick_r == 4'h1)
    else $error("start edge not aligned");

endmodule // fifo_serial_port

// File: dv/serial_peer.sv
// Remote serial device: decodes TxD frames and sends frames on RxD.
// Assumes a bit period of BIT_CYC clk cycles and a pull-up on TxD.
module serial_peer #(
  parameter int BIT_CYC = 64
) (
  input  wire logic                   clk,
  input  wire logic                   txd_out,
  input  wire logic                   txd_oe,
  input  wire uart_pkg::serial_mode_s mode,
  output logic                        rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  import uart_pkg::*;

  logic       line;
  logic [7:0] got_byte;
  logic       got_par;
  logic       stop_ok;
  int         got_cnt;

  // Undriven TxD floats to its pull-up
  assign line = txd_oe ? txd_out : 1'b1;

  task automatic bit_wait();
    repeat (BIT_CYC) @(posedge clk);
  endtask

  initial begin
    rxd = 1'b1;
    got_cnt = 0;
  end

  // ----------------------------------------
  // Frame decoder, samples at mid bit
  // ----------------------------------------
  always begin : decode
    @(negedge line);
    repeat (BIT_CYC / 2) @(posedge clk);
    if (line === 1'b0) begin
      got_byte = 8'h00;
      for (int i = 0; i < (mode.char_7bit ? 7 : 8); i++) begin
        bit_wait();
        got_byte[i] = line;
      end
      if (mode.parity_enable) begin
        bit_wait();
        got_par = line;
      end
      bit_wait();
      stop_ok = line;
      if (mode.two_stop) begin
        bit_wait();
        stop_ok = stop_ok & line;
      end
      got_cnt++;
    end
  end

  // ----------------------------------------
  // Frame sender on RxD
  // ----------------------------------------
  task automatic send(input logic [7:0] b);
    logic q[$];
    logic p;
    p = mode.parity_odd;
    q.push_back(1'b0);
    for (int i = 0; i < (mode.char_7bit ? 7 : 8); i++) begin
      q.push_back(b[i]);
      p ^= b[i];
    end
    if (mode.parity_enable) q.push_back(p);
    q.push_back(1'b1);
    if (mode.two_stop) q.push_back(1'b1);
    foreach (q[k]) begin
      @(negedge clk);
      rxd = q[k];
      repeat (BIT_CYC - 1) @(negedge clk);
    end
  endtask
endmodule // serial_peer

// File: dv/test_fifo_serial_port.sv
// Bench for the serial port core: clock select, enables, frame formats.
// Assumes the peer model on TxD/RxD and a 16x tick of four clk cycles.
module test_fifo_serial_port;
  timeunit 1ns;
  timeprecision 1ns;
  import uart_pkg::*;

  localparam int BIT_CYC = 64;

  logic            clk, srst, ctrl_we, sck_in, sck_out, sck_oe, ext_on;
  logic            tx_valid, tx_ready, transmit_end_flag, txd_out, txd_oe;
  logic            rxd_in, rx_valid, rx_frame_err, rx_parity_err;
  logic [7:0]      bit_rate, tx_data, rx_data;
  logic [1:0]      sel_now;
  serial_control_s ctrl;
  serial_mode_s    mode;
  int              miscompares, cmp_count;

  fifo_serial_port fifo_serial_port_inst (
    .clk(clk), .srst(srst), .ctrl(ctrl), .ctrl_we(ctrl_we), .mode(mode),
    .bit_rate(bit_rate), .sck_in(sck_in), .sck_out(sck_out),
    .sck_oe(sck_oe), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .transmit_end_flag(transmit_end_flag),
    .txd_out(txd_out), .txd_oe(txd_oe), .rxd_in(rxd_in),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_frame_err(rx_frame_err),
    .rx_parity_err(rx_parity_err));

  serial_peer #(.BIT_CYC(BIT_CYC)) serial_peer_inst (
    .clk(clk), .txd_out(txd_out), .txd_oe(txd_oe), .mode(mode),
    .rxd(rxd_in));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // External 16x clock runs through init and operation
  initial begin
    sck_in = 1'b0;
    forever begin
      repeat (2) @(negedge clk);
      if (ext_on) sck_in = ~sck_in;
    end
  end

  initial begin
    #1600000;
    miscompares++;
    end_of_test();
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic set_ctrl(input logic [1:0] sel, input logic te, re);
    @(negedge clk);
    ctrl = '{1'b0, 1'b0, te, re, sel[1], sel[0]};
    ctrl_we = 1'b1;
    @(negedge clk);
    ctrl_we = 1'b0;
  endtask

  task automatic reformat(input serial_mode_s m);
    set_ctrl(sel_now, 1'b0, 1'b0);
    mode = m;
    repeat (BIT_CYC) @(negedge clk);
    set_ctrl(sel_now, 1'b1, 1'b1);
  endtask

  task automatic send_byte(input logic [7:0] b);
    int n;
    @(negedge clk);
    tx_data = b;
    tx_valid = 1'b1;
    n = 0;
    while (tx_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    tx_valid = 1'b0;
    check("tx_ready", 8'h01, {7'h0, tx_ready});
  endtask

  task automatic wait_frame(input int c0);
    int n;
    n = 0;
    while (serial_peer_inst.got_cnt == c0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000) miscompares++;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic clk_out();
    int r;
    logic prev;
    sel_now = 2'b01;
    set_ctrl(2'b01, 1'b0, 1'b0);
    @(negedge clk);
    check("sck_oe", 8'h01, {7'h0, sck_oe});
    check("txd_oe_off", 8'h00, {7'h0, txd_oe});
    r = 0;
    prev = sck_out;
    repeat (BIT_CYC) begin
      @(negedge clk);
      if (sck_out === 1'b1 && prev === 1'b0) r++;
      prev = sck_out;
    end
    check("sck_rises", 8'h10, r[7:0]);
  endtask

  task automatic tx_frame(input serial_mode_s m, input logic [7:0] b);
    int c0;
    logic [7:0] k;
    logic p;
    reformat(m);
    check("mark_idle", 8'h03, {6'h0, txd_oe, txd_out});
    k = m.char_7bit ? 8'h7f : 8'hff;
    p = m.parity_odd ^ (^(b & k));
    c0 = serial_peer_inst.got_cnt;
    send_byte(b);
    @(negedge clk);
    check("end_busy", 8'h00, {7'h0, transmit_end_flag});
    wait_frame(c0);
    check("tx_byte", b & k, serial_peer_inst.got_byte);
    if (m.parity_enable)
      check("tx_par", {7'h0, p}, {7'h0, serial_peer_inst.got_par});
    check("tx_stop", 8'h01, {7'h0, serial_peer_inst.stop_ok});
    repeat (BIT_CYC) @(negedge clk);
    check("end_idle", 8'h01, {7'h0, transmit_end_flag});
    check("mark_after", 8'h03, {6'h0, txd_oe, txd_out});
  endtask

  task automatic rx_frame(input serial_mode_s m, input logic [7:0] b);
    int n;
    logic [7:0] k, got;
    logic [1:0] errs;
    reformat(m);
    k = m.char_7bit ? 8'h7f : 8'hff;
    n = 0;
    fork
      serial_peer_inst.send(b);
      begin
        while (rx_valid !== 1'b1 && n < 1200) begin
          @(negedge clk);
          n++;
        end
        got = rx_data;
        errs = {rx_frame_err, rx_parity_err};
      end
    join
    if (n >= 1200) miscompares++;
    check("rx_byte", b & k, got & k);
    check("rx_errs", 8'h00, {6'h0, errs});
  endtask

  task automatic tx_abort();
    int c0;
    c0 = serial_peer_inst.got_cnt;
    send_byte(8'h00);
    repeat (3 * BIT_CYC) @(negedge clk);
    set_ctrl(sel_now, 1'b0, 1'b1);
    @(negedge clk);
    check("txd_oe_abort", 8'h00, {7'h0, txd_oe});
    wait_frame(c0);
    tx_frame(serial_mode_s'(4'h0), 8'h5a);
  endtask

  task automatic sel_case(input logic [1:0] sel, input logic [7:0] b);
    sel_now = sel;
    set_ctrl(sel, 1'b0, 1'b0);
    repeat (2) @(negedge clk);
    check("sck_oe_sel", 8'h00, {7'h0, sck_oe});
    tx_frame(serial_mode_s'(4'h0), b);
  endtask

  initial begin
    srst = 1'b1;
    ctrl = '0;
    ctrl_we = 1'b0;
    mode = '0;
    bit_rate = 8'h01;
    tx_data = 8'h00;
    tx_valid = 1'b0;
    ext_on = 1'b1;
    sel_now = 2'b00;
    miscompares = 0;
    cmp_count = 0;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    check("reset_outs", 8'h0c, {1'b0, sck_oe, sck_out, txd_oe, txd_out,
          transmit_end_flag, tx_ready, rx_valid});
    clk_out();
    tx_frame(serial_mode_s'(4'b0000), 8'ha5);
    tx_frame(serial_mode_s'(4'b0101), 8'h3c);
    tx_frame(serial_mode_s'(4'b1110), 8'hd9);
    tx_frame(serial_mode_s'(4'b1001), 8'he6);
    rx_frame(serial_mode_s'(4'b0100), 8'h6b);
    rx_frame(serial_mode_s'(4'b1111), 8'hb4);
    tx_abort();
    sel_case(2'b00, 8'h81);
    bit_rate = 8'h00;
    sel_case(2'b10, 8'hc3);
    sel_case(2'b11, 8'h96);
    rx_frame(serial_mode_s'(4'b0000), 8'h2d);
    end_of_test();
  end
endmodule // test_fifo_serial_port
